// File: rtl/nvsc_host.sv
`timescale 1ns/1ps
module nvsc_host #(
  parameter int STORE_CYCLES = nvsc_pkg::STORE_CYC,
  parameter int RECALL_CYCLES = nvsc_pkg::RECALL_CYC,
  parameter int POWERUP_CYCLES = nvsc_pkg::POWERUP_CYC,
  parameter int PULSE_CYCLES = nvsc_pkg::INIT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reqValid,
  input wire logic [1:0] reqOp,
  input wire logic [14:0] reqAddr,
  input wire logic [7:0] reqWdata,
  output logic reqReady,
  output logic rspValid,
  output logic [7:0] rspRdata,
  output logic memChipEnN,
  output logic memWriteEnN,
  output logic memOutEnN,
  output logic [14:0] memAddr,
  output logic [7:0] dataIoOut,
  output logic dataIoOe,
  input wire logic [7:0] dataIoIn
);
  typedef enum logic [2:0] {
    NVSC_WAIT, NVSC_IDLE, NVSC_SETUP, NVSC_PULSE, NVSC_GAP, NVSC_BUSY
  } nvsc_state_e;

  nvsc_state_e state;
  logic [nvsc_pkg::CNT_W-1:0] timer;
  logic [2:0] step;
  logic [1:0] op;
  logic take;
  logic pulseEnd;
  logic nextStep;

  // address of a given command step, low bits only, top bit held zero
  function automatic logic [14:0] seq_addr(input logic [2:0] s,
                                           input logic rec);
    logic [13:0] a;
    a = nvsc_pkg::SEQ_A0;
    case (s)
      3'h0: a = nvsc_pkg::SEQ_A0;
      3'h1: a = nvsc_pkg::SEQ_A1;
      3'h2: a = nvsc_pkg::SEQ_A2;
      3'h3: a = nvsc_pkg::SEQ_A3;
      3'h4: a = nvsc_pkg::SEQ_A4;
      default: a = rec ? nvsc_pkg::SEQ_RECALL : nvsc_pkg::SEQ_STORE;
    endcase
    return {1'b0, a};
  endfunction : seq_addr

  function automatic logic [nvsc_pkg::CNT_W-1:0] cyc(input int n);
    return nvsc_pkg::CNT_W'(n - 1);
  endfunction : cyc

  // milestones shared by the blocks below
  assign take = (state == NVSC_IDLE) && reqValid;
  assign pulseEnd = (state == NVSC_PULSE) && (timer == '0);
  assign nextStep = (state == NVSC_GAP) && op[1] && (step != 3'h5);

  // main sequencer: one access or one six-read command at a time
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state <= NVSC_WAIT;
    else
    begin
      case (state)
        NVSC_WAIT:
          if (timer == '0)
            state <= NVSC_IDLE;
        NVSC_IDLE:
          if (reqValid)
            state <= NVSC_SETUP;
        NVSC_SETUP:
          state <= NVSC_PULSE;
        NVSC_PULSE:
          if (timer == '0)
            state <= NVSC_GAP;
        NVSC_GAP:
          if (nextStep)
            state <= NVSC_SETUP;
          else if (op[1])
            state <= NVSC_WAIT;
          else
            state <= NVSC_IDLE;
        default:
          state <= NVSC_WAIT;
      endcase
    end
  end

  // one down-counter times the pulse, the busy spell and power-up
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      timer <= cyc(POWERUP_CYCLES);
    else
    begin
      case (state)
        NVSC_WAIT, NVSC_PULSE:
          if (timer != '0)
            timer <= timer - 1'b1;
        NVSC_SETUP:
          timer <= cyc(PULSE_CYCLES);
        NVSC_GAP:
          if (op == 2'(nvsc_pkg::NVSC_OP_STORE))
            timer <= cyc(STORE_CYCLES);
          else if (op == 2'(nvsc_pkg::NVSC_OP_RECALL))
            timer <= cyc(RECALL_CYCLES);
        default:
          timer <= timer;
      endcase
    end
  end

  // operation and command step, latched when a request is taken
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      step <= 3'h0;
      op <= 2'h0;
    end
    else if (take)
    begin
      op <= reqOp;
      step <= 3'h0;
    end
    else if (nextStep)
      step <= step + 3'h1;
  end

  // request handshake and response; commands answer by ready alone
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspRdata <= 8'h00;
    end
    else
    begin
      rspValid <= 1'b0;
      if (state == NVSC_WAIT && timer == '0)
        reqReady <= 1'b1;
      else if (take)
        reqReady <= 1'b0;
      else if (state == NVSC_GAP && !op[1])
      begin
        reqReady <= 1'b1;
        rspValid <= (op == 2'(nvsc_pkg::NVSC_OP_WRITE));
      end
      if (pulseEnd && op == 2'(nvsc_pkg::NVSC_OP_READ))
      begin
        rspRdata <= dataIoIn;
        rspValid <= 1'b1;
      end
    end
  end

  // device strobes: write enable settles before chip enable falls
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      memChipEnN <= 1'b1;
      memWriteEnN <= 1'b1;
      memOutEnN <= 1'b1;
    end
    else
    begin
      if (take)
        memWriteEnN <= (reqOp != 2'(nvsc_pkg::NVSC_OP_WRITE));
      else if (state == NVSC_GAP)
        memWriteEnN <= 1'b1;
      if (state == NVSC_SETUP)
      begin
        memChipEnN <= 1'b0;
        memOutEnN <= (op != 2'(nvsc_pkg::NVSC_OP_READ));
      end
      else if (pulseEnd)
      begin
        memChipEnN <= 1'b1;
        memOutEnN <= 1'b1;
      end
    end
  end

  // device address and write data, released after chip enable rises
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      memAddr <= 15'h0000;
      dataIoOut <= 8'h00;
      dataIoOe <= 1'b0;
    end
    else
    begin
      if (take && !reqOp[1])
        memAddr <= reqAddr;
      else if (take)
        memAddr <= seq_addr(3'h0, reqOp[0]);
      else if (nextStep)
        memAddr <= seq_addr(step + 3'h1, op[0]);
      if (take && reqOp == 2'(nvsc_pkg::NVSC_OP_WRITE))
      begin
        dataIoOut <= reqWdata;
        dataIoOe <= 1'b1;
      end
      else if (state == NVSC_GAP)
        dataIoOe <= 1'b0;
    end
  end
endmodule : nvsc_host

// File: rtl/nvsc_pkg.sv
package nvsc_pkg;
  // address width of the memory and of the command match
  localparam int ADDR_W = 15;
  localparam int CMD_W = 14;
  localparam int DATA_W = 8;
  // command sequence addresses
  localparam logic [13:0] SEQ_A0 = 14'h0e38;
  localparam logic [13:0] SEQ_A1 = 14'h31c7;
  localparam logic [13:0] SEQ_A2 = 14'h03e0;
  localparam logic [13:0] SEQ_A3 = 14'h3c1f;
  localparam logic [13:0] SEQ_A4 = 14'h303f;
  localparam logic [13:0] SEQ_STORE = 14'h0fc0;
  localparam logic [13:0] SEQ_RECALL = 14'h0c63;
  // clock and timing
  localparam int CLK_MHZ = 50;
  localparam int CLK_NS = 20;
  localparam int INIT_CYCLE_NS = 45;
  localparam int STORE_MS = 10;
  localparam int RECALL_US = 20;
  localparam int POWERUP_RECALL_US = 550;
  // least times round up, never below one cycle
  localparam int INIT_CYC = (INIT_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STORE_CYC = STORE_MS * 1000 * CLK_MHZ;
  localparam int RECALL_CYC = RECALL_US * CLK_MHZ;
  localparam int POWERUP_CYC = POWERUP_RECALL_US * CLK_MHZ;
  localparam int CNT_W = 24;
  // host operations
  typedef enum logic [1:0] {
    NVSC_OP_READ,
    NVSC_OP_WRITE,
    NVSC_OP_STORE,
    NVSC_OP_RECALL
  } nvsc_op_e;
endpackage : nvsc_pkg

// File: testbench/nvsc_dev.sv
`timescale 1ns/1ps
// behavioural nonvolatile sram behind the host strobes
module nvsc_dev (
  input wire logic memChipEnN,
  input wire logic memWriteEnN,
  input wire logic memOutEnN,
  input wire logic [14:0] memAddr,
  input wire logic [7:0] dataIoOut,
  output logic [7:0] devQ,
  output logic devOe,
  output int nStore,
  output int nRecall
);
  logic [7:0] sram [32768], nv [32768];
  logic [13:0] seq [5] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f, 14'h303f};
  logic busy = 1, weFirst = 0;
  logic [13:0] a;
  int step = 0, s;
  initial {nStore, nRecall} = 0;
  initial #500 busy = 0;
  // a read begun with write enable low never drives
  always @(negedge memChipEnN) weFirst = !memWriteEnN;
  assign devQ = sram[memAddr];
  assign devOe = !memChipEnN && !memOutEnN && memWriteEnN && !weFirst
    && !busy;
  // each access completes at the chip enable rising edge
  always @(posedge memChipEnN)
  begin
    a = memAddr[13:0];
    s = step;
    step = 0;
    if (!busy && !memWriteEnN)
      sram[memAddr] = dataIoOut;
    else if (!busy && s == 5 && a == 14'h0fc0)
    begin
      nv = sram;
      nStore++;
      busy = 1;
      busy <= #800 0;
    end
    else if (!busy && s == 5 && a == 14'h0c63)
    begin
      sram = nv;
      nRecall++;
      busy = 1;
      busy <= #300 0;
    end
    else if (!busy)
      step = (s < 5 && a == seq[s]) ? s + 1 : int'(a == 14'h0e38);
  end
endmodule : nvsc_dev

// File: testbench/nvsc_host_assertions.sv
`timescale 1ns/1ps
// strobe checks on the host's device side
module nvsc_host_chk #(
  parameter int STORE_CYCLES = 50,
  parameter int RECALL_CYCLES = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic memChipEnN,
  input wire logic memWriteEnN,
  input wire logic memOutEnN,
  input wire logic [14:0] memAddr,
  input wire logic dataIoOe
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_write_drive:
    assert property (!memChipEnN && !memWriteEnN |-> dataIoOe)
    else $error("write without data");
  a_read_we:
    assert property (!memOutEnN |-> memWriteEnN && !dataIoOe)
    else $error("read with we low");
  a_pulse_width:
    assert property ($fell(memChipEnN) |-> !memChipEnN [*3] ##1 memChipEnN)
    else $error("bad ce width");
  a_addr_stable:
    assert property (!memChipEnN |-> $stable(memAddr) && $stable(memWriteEnN))
    else $error("addr moved");
  a_seq_order:
    assert property ($fell(memChipEnN) && memOutEnN && memWriteEnN
      && memAddr == 15'h0e38
      |-> ##5 memAddr == 15'h31c7) else $error("bad order");
  a_cmd_top:
    assert property ($fell(memChipEnN) && memOutEnN && memWriteEnN
      |-> !memAddr[14]) else $error("top bit set");
  a_store_wait:
    assert property ($rose(memChipEnN) && memWriteEnN && $past(memOutEnN)
      && memAddr == 15'h0fc0 |=> memChipEnN throughout ##STORE_CYCLES 1'b1)
    else $error("store cut short");
  a_recall_wait:
    assert property ($rose(memChipEnN) && memWriteEnN && $past(memOutEnN)
      && memAddr == 15'h0c63 |=> memChipEnN throughout ##RECALL_CYCLES 1'b1)
    else $error("recall cut short");
endmodule : nvsc_host_chk
bind nvsc_host nvsc_host_chk #(.STORE_CYCLES(STORE_CYCLES),
  .RECALL_CYCLES(RECALL_CYCLES)) chk (.*);

// File: testbench/nvsc_host_bench.sv
`timescale 1ns/1ps
// host controller bench with a behavioural device behind it
module nvsc_host_bench;
  logic clk = 0, sys_rst = 1, reqValid = 0;
  logic [1:0] reqOp = 0;
  logic [14:0] reqAddr = 0, memAddr;
  logic [7:0] reqWdata = 0, dataIoIn, rspRdata, dataIoOut, devQ;
  logic reqReady, rspValid, memChipEnN, memWriteEnN, memOutEnN, dataIoOe;
  logic devOe;
  int nStore, nRecall, nErrors = 0, samplesChecked = 0, cycles = 0;
  // op, address, write data, expected read data
  logic [32:0] rows [9] = '{{2'h1, 15'h1234, 16'ha500},
    {2'h1, 15'h5234, 16'h3c00}, {2'h0, 15'h1234, 16'h00a5},
    {2'h2, 15'h7fff, 16'h0}, {2'h1, 15'h1234, 16'h0},
    {2'h0, 15'h1234, 16'h0}, {2'h3, 15'h7fff, 16'h0},
    {2'h0, 15'h1234, 16'h00a5}, {2'h0, 15'h5234, 16'h003c}};
  nvsc_host #(.STORE_CYCLES(50), .RECALL_CYCLES(20), .POWERUP_CYCLES(30),
    .PULSE_CYCLES(3)) uut (.*);
  nvsc_dev dev (.*);
  // released bus shows a pattern that changes every half cycle
  assign dataIoIn = dataIoOe ? dataIoOut : devOe ? devQ : {8{clk}} ^ 8'h5a;
  always #10 clk = ~clk;
  // hang guard
  always @(posedge clk)
    if (++cycles == 2000)
    begin
      nErrors++;
      wrapUp();
    end
  task automatic chk(input logic [7:0] got, exp);
    samplesChecked++;
    if (got !== exp)
    begin
      nErrors++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask : chk
  task automatic req(input logic [32:0] r);
    {reqOp, reqAddr, reqWdata} <= r[32:8];
    reqValid <= 1'h1;
    @(posedge clk);
    while (reqReady !== 1'h1) @(posedge clk);
    reqValid <= 1'h0;
    while (r[32] === 1'h0 && rspValid !== 1'h1) @(posedge clk);
    if (r[32:31] === 2'h0) chk(rspRdata, r[7:0]);
    @(posedge clk);
    // a command is done only when the host is ready again
    while (r[32] === 1'h1 && reqReady !== 1'h1) @(posedge clk);
  endtask : req
  task automatic wrapUp();
    if (nErrors == 0 && samplesChecked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrapUp
  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    foreach (rows[i]) req(rows[i]);
    chk(8'(nStore), 8'h1);
    chk(8'(nRecall), 8'h1);
    // reset in mid-run, then two commands back to back
    sys_rst <= 1'h1;
    @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    chk({3'h0, reqReady, memChipEnN, memWriteEnN, memOutEnN, dataIoOe},
      8'h0e);
    req({2'h2, 15'h0, 16'h0});
    req({2'h3, 15'h0, 16'h0});
    chk(8'(nStore + nRecall), 8'h4);
    req({2'h0, 15'h1234, 16'h00a5});
    wrapUp();
  end
endmodule : nvsc_host_bench
